// ==== ptm_pins.sv ====
// Pin source model: external clock pin and capture input pin
`timescale 1ns/10ps
module ptm_pins (
	// Clock
	input wire logic clk,
	// Driven pins
	output logic external_clock_pin,
	output logic capture_input_pin
);
	// Both sources idle low; push-pull, so no released state
	initial begin
		external_clock_pin = 1'b0;
		capture_input_pin = 1'b0;
	end
	// Each level held 3 clocks so the synchronous pin sampler cannot miss it
	task automatic ext_pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			external_clock_pin <= 1'b1;
			repeat (3) @(posedge clk);
			external_clock_pin <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
	// One level change on the capture input
	task automatic cap_level(input logic v);
		@(posedge clk);
		capture_input_pin <= v;
		repeat (3) @(posedge clk);
	endtask
endmodule

// ==== ptm_pkg.sv ====
// Constants and types shared by the periodic timer module
package ptm_pkg;

	// Register byte addresses on the APB bus, one word each
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_CTRL1 = 8'h04;
	localparam logic [7:0] ADDR_CAPC = 8'h08;
	localparam logic [7:0] ADDR_CNT_LO = 8'h0C;
	localparam logic [7:0] ADDR_CNT_HI = 8'h10;
	localparam logic [7:0] ADDR_CA_LO = 8'h14;
	localparam logic [7:0] ADDR_CA_HI = 8'h18;
	localparam logic [7:0] ADDR_CB_LO = 8'h1C;
	localparam logic [7:0] ADDR_CB_HI = 8'h20;
	localparam logic [7:0] ADDR_CP_LO = 8'h24;
	localparam logic [7:0] ADDR_CP_HI = 8'h28;

	// Control register zero fields
	localparam int C0_PAUSE = 7;
	localparam int C0_CKSEL_LO = 4;
	localparam int C0_RUN = 3;

	// Control register one fields
	localparam int C1_MODE_LO = 6;
	localparam int C1_PINF_LO = 4;
	localparam int C1_INIT = 3;
	localparam int C1_INV = 2;
	localparam int C1_CAPSRC = 1;
	localparam int C1_CLRSRC = 0;

	// Capture control fields
	localparam int CC_CLR_LO = 1;
	localparam int CC_VLF = 0;

	// Reset values of the control registers
	localparam logic [7:0] CTRL0_RST = 8'h00;
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [2:0] CAPC_RST = 3'h0;

	// Counter clock select codes
	localparam logic [2:0] CK_SYS4 = 3'h0;
	localparam logic [2:0] CK_SYS = 3'h1;
	localparam logic [2:0] CK_H16 = 3'h2;
	localparam logic [2:0] CK_H64 = 3'h3;
	localparam logic [2:0] CK_SUB0 = 3'h4;
	localparam logic [2:0] CK_SUB1 = 3'h5;
	localparam logic [2:0] CK_EXT_R = 3'h6;
	localparam logic [2:0] CK_EXT_F = 3'h7;

	// Timing: system clock period and sub clock period in ns
	localparam int CLK_PERIOD_NS = 50;
	localparam int SUB_PERIOD_NS = 31250;
	localparam int SUB_DIV = SUB_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [15:0] CNT_MAX = 16'hFFFF;

	// Operating modes in field order
	typedef enum logic [1:0] {MODE_CMP, MODE_CAP, MODE_PWM, MODE_TMR} ptm_mode_e;

endpackage

// ==== ptm_timer.sv ====
// Periodic timer: 16-bit up counter, compare, PWM, pulse and capture
//
// Notes on behaviour
// - 16-bit counter, comparators A and P
// - software clears counter only by run rise
// - overflow or selected match clears counter
// - pause holds counter, clearing resumes it
// - three-bit field selects counter clock source
// - run rise zeroes counter; run low holds
// - run rise restores output initial level in compare and PWM modes
// - two-bit field selects operating mode
// - compare mode pin action on A match
// - PWM mode pin function selects output
// - capture edges latch counter into A
// - nonzero capture-clear latches into B instead
// - second output is inverse of primary
// - counter read only, compares read/write
// - control zero low bits read zero
// - capture-clear field adds edge clear conditions
// - capture source: capture pin or clock pin
// - clear source bit: A match or period
// - initial-level bit sets pre-match/active level
//
// Design decisions made here: the address map and register access over APB.
`timescale 1ns/10ps
module ptm_timer
	import ptm_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer pins
	input wire logic external_clock_pin,
	input wire logic capture_input_pin,
	output logic primary_timer_output,
	output logic inverse_timer_output,
	// Timer events, one cycle each
	output logic match_a_event,
	output logic match_p_event
);

	typedef struct packed {
		logic [7:0] ctrl0;
		logic [7:0] ctrl1;
		logic [1:0] cap_clear;
		logic latch_edge_flag;
		logic [15:0] cnt;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [15:0] period;
		logic run_q;
		logic out_lvl;
		logic ext_q;
		logic cap_q;
		logic [5:0] pre;
		logic [9:0] sub;
		logic ev_a;
		logic ev_p;
		logic [31:0] rdata;
	} ptm_state_s;

	ptm_state_s s_reg;
	ptm_state_s s_next;

	ptm_mode_e mode;
	logic [1:0] pin_func;
	logic [2:0] ck_sel;
	logic run;
	logic run_rise;
	logic tick;
	logic ext_rise;
	logic ext_fall;
	logic src_rise;
	logic src_fall;
	logic period_hit;
	logic hit_a;
	logic clr;
	logic cap_ev;
	logic cap_clr;
	logic single_pulse;
	logic setup;
	logic access;
	logic mapped;
	logic [7:0] rd_byte;

	// Field views of the control registers
	assign mode = ptm_mode_e'(s_reg.ctrl1[C1_MODE_LO +: 2]);
	assign pin_func = s_reg.ctrl1[C1_PINF_LO +: 2];
	assign ck_sel = s_reg.ctrl0[C0_CKSEL_LO +: 3];
	assign run = s_reg.ctrl0[C0_RUN];
	assign run_rise = run & ~s_reg.run_q;
	assign single_pulse = (mode == MODE_PWM) && (pin_func == 2'h3);

	// Pin edges; pins are synchronous so one stage is enough
	assign ext_rise = external_clock_pin & ~s_reg.ext_q;
	assign ext_fall = ~external_clock_pin & s_reg.ext_q;
	assign src_rise = s_reg.ctrl1[C1_CAPSRC] ? ext_rise : (capture_input_pin & ~s_reg.cap_q);
	assign src_fall = s_reg.ctrl1[C1_CAPSRC] ? ext_fall : (~capture_input_pin & s_reg.cap_q);

	// Counter clock enable from the selected source
	always_comb begin
		case (ck_sel)
			CK_SYS4: tick = (s_reg.pre[1:0] == 2'h3);
			CK_SYS: tick = 1'b1;
			CK_H16: tick = (s_reg.pre[3:0] == 4'hF);
			CK_H64: tick = (s_reg.pre == 6'h3F);
			CK_SUB0, CK_SUB1: tick = (s_reg.sub == 10'(SUB_DIV - 1));
			CK_EXT_R: tick = ext_rise;
			CK_EXT_F: tick = ext_fall;
			default: tick = 1'b0;
		endcase
		// Paused or stopped counter sees no clock
		tick = tick & run & ~s_reg.ctrl0[C0_PAUSE] & ~run_rise;
	end

	// Comparators work across all sixteen bits
	assign hit_a = (s_reg.cnt == s_reg.cmp_a);
	// A zero period lets the counter run to its maximum
	assign period_hit = (s_reg.period == 16'h0000) ? (s_reg.cnt == CNT_MAX) : (s_reg.cnt == s_reg.period);

	// Clear condition for the present mode
	always_comb begin
		case (mode)
			MODE_CMP, MODE_TMR: clr = s_reg.ctrl1[C1_CLRSRC] ? hit_a : period_hit;
			MODE_CAP: clr = period_hit;
			MODE_PWM: clr = single_pulse ? 1'b0 : period_hit;
			default: clr = 1'b0;
		endcase
	end

	// Capture edge selection and edge-driven clear
	always_comb begin
		cap_ev = 1'b0;
		cap_clr = 1'b0;
		if (mode == MODE_CAP && run) begin
			case (pin_func)
				2'h0: cap_ev = src_rise;
				2'h1: cap_ev = src_fall;
				2'h2: cap_ev = src_rise | src_fall;
				default: cap_ev = 1'b0;
			endcase
			case (s_reg.cap_clear)
				2'h1: cap_clr = src_rise;
				2'h2: cap_clr = src_fall;
				2'h3: cap_clr = src_rise | src_fall;
				default: cap_clr = 1'b0;
			endcase
		end
	end

	// APB phases and address decode
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign pready = access;
	assign pslverr = access & ~mapped;

	always_comb begin
		mapped = 1'b1;
		case (paddr)
			ADDR_CTRL0: rd_byte = {s_reg.ctrl0[7:3], 3'h0};
			ADDR_CTRL1: rd_byte = s_reg.ctrl1;
			ADDR_CAPC: rd_byte = {5'h00, s_reg.cap_clear, s_reg.latch_edge_flag};
			ADDR_CNT_LO: rd_byte = s_reg.cnt[7:0];
			ADDR_CNT_HI: rd_byte = s_reg.cnt[15:8];
			ADDR_CA_LO: rd_byte = s_reg.cmp_a[7:0];
			ADDR_CA_HI: rd_byte = s_reg.cmp_a[15:8];
			ADDR_CB_LO: rd_byte = s_reg.cmp_b[7:0];
			ADDR_CB_HI: rd_byte = s_reg.cmp_b[15:8];
			ADDR_CP_LO: rd_byte = s_reg.period[7:0];
			ADDR_CP_HI: rd_byte = s_reg.period[15:8];
			default: begin
				rd_byte = 8'h00;
				mapped = 1'b0;
			end
		endcase
	end

	// Next state of the whole block
	always_comb begin
		s_next = s_reg;
		s_next.ev_a = 1'b0;
		s_next.ev_p = 1'b0;
		s_next.run_q = run;
		s_next.ext_q = external_clock_pin;
		s_next.cap_q = capture_input_pin;
		s_next.pre = s_reg.pre + 6'h01;
		s_next.sub = (s_reg.sub == 10'(SUB_DIV - 1)) ? 10'h000 : s_reg.sub + 10'h001;

		// Read data is sampled in the setup phase so it comes from a flop
		if (setup) begin
			s_next.rdata = {24'h000000, rd_byte};
		end

		// Register writes; the counter has no write path
		if (access && pwrite) begin
			case (paddr)
				ADDR_CTRL0: s_next.ctrl0 = {pwdata[7:3], 3'h0};
				ADDR_CTRL1: s_next.ctrl1 = pwdata[7:0];
				ADDR_CAPC: s_next.cap_clear = pwdata[CC_CLR_LO +: 2];
				ADDR_CA_LO: s_next.cmp_a[7:0] = pwdata[7:0];
				ADDR_CA_HI: s_next.cmp_a[15:8] = pwdata[7:0];
				ADDR_CB_LO: s_next.cmp_b[7:0] = pwdata[7:0];
				ADDR_CB_HI: s_next.cmp_b[15:8] = pwdata[7:0];
				ADDR_CP_LO: s_next.period[7:0] = pwdata[7:0];
				ADDR_CP_HI: s_next.period[15:8] = pwdata[7:0];
				default: ;
			endcase
		end

		// Run rise: counter to zero, output to its initial level in compare and PWM modes
		if (run_rise) begin
			s_next.cnt = 16'h0000;
			if (mode != MODE_CAP && mode != MODE_TMR) begin
				s_next.out_lvl = s_reg.ctrl1[C1_INIT];
			end
		end else if (tick) begin
			// Wrap from the maximum counts as overflow
			s_next.cnt = clr ? 16'h0000 : s_reg.cnt + 16'h0001;
		end

		// Match events and their effect on the output
		if (tick) begin
			case (mode)
				MODE_CMP, MODE_TMR: begin
					// A zero compare A never reports a match
					s_next.ev_a = hit_a && (s_reg.cmp_a != 16'h0000);
					s_next.ev_p = period_hit && !s_reg.ctrl1[C1_CLRSRC];
					if (mode == MODE_CMP && s_next.ev_a) begin
						case (pin_func)
							2'h1: s_next.out_lvl = 1'b0;
							2'h2: s_next.out_lvl = 1'b1;
							2'h3: s_next.out_lvl = ~s_reg.out_lvl;
							default: ;
						endcase
					end
				end
				MODE_CAP: s_next.ev_p = period_hit;
				MODE_PWM: begin
					s_next.ev_a = hit_a;
					s_next.ev_p = period_hit && !single_pulse;
					// Pulse ends on A match, which also stops the timer
					if (single_pulse && hit_a) begin
						s_next.ctrl0[C0_RUN] = 1'b0;
						s_next.out_lvl = ~s_reg.ctrl1[C1_INIT];
					end
				end
				default: ;
			endcase
		end

		// PWM output levels: forced by pin function 0 or 1, counter against compare A for 2
		if (mode == MODE_PWM && !run_rise) begin
			case (pin_func)
				2'h0: s_next.out_lvl = ~s_reg.ctrl1[C1_INIT];
				2'h1: s_next.out_lvl = s_reg.ctrl1[C1_INIT];
				2'h2: s_next.out_lvl = (s_reg.cnt < s_reg.cmp_a) ? s_reg.ctrl1[C1_INIT] : ~s_reg.ctrl1[C1_INIT];
				default: ;
			endcase
		end

		// Single pulse may be triggered by the clock pin's rising edge
		if (single_pulse && !run && ext_rise) begin
			s_next.ctrl0[C0_RUN] = 1'b1;
		end

		// Capture and edge clear win over a software write in the same cycle
		if (cap_ev) begin
			s_next.ev_a = 1'b1;
			if (s_reg.cap_clear == 2'h0) begin
				s_next.cmp_a = s_reg.cnt;
			end else begin
				s_next.cmp_b = s_reg.cnt;
				s_next.latch_edge_flag = src_rise;
			end
		end
		if (cap_clr && !run_rise) begin
			s_next.cnt = 16'h0000;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs; polarity is not applied in timer/counter mode
	assign primary_timer_output = s_reg.out_lvl ^ (s_reg.ctrl1[C1_INV] & (mode != MODE_TMR));
	assign inverse_timer_output = ~primary_timer_output;
	assign prdata = s_reg.rdata;
	assign match_a_event = s_reg.ev_a;
	assign match_p_event = s_reg.ev_p;

	// Checks on the counter, output and register behaviour
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_no_sw_load;
		!tick && !run_rise && !cap_clr |=> $stable(s_reg.cnt);
	endproperty
	a_no_sw_load: assert property (p_no_sw_load) else $error("counter moved without cause");

	property p_pause_hold;
		s_reg.ctrl0[C0_PAUSE] && !run_rise && !cap_clr |=> $stable(s_reg.cnt);
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("counter moved while paused");

	property p_run_rise_zero;
		run_rise |=> s_reg.cnt == 16'h0000;
	endproperty
	a_run_rise_zero: assert property (p_run_rise_zero) else $error("run rise did not clear counter");

	property p_stopped_hold;
		!run && !s_reg.run_q |=> $stable(s_reg.cnt);
	endproperty
	a_stopped_hold: assert property (p_stopped_hold) else $error("stopped counter moved");

	property p_inverse;
		inverse_timer_output != primary_timer_output;
	endproperty
	a_inverse: assert property (p_inverse) else $error("inverse output not inverted");

	property p_wrap;
		tick && !run_rise && s_reg.cnt == CNT_MAX |=> s_reg.cnt == 16'h0000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap");

	property p_clear_event;
		tick && clr && !run_rise |=> s_reg.cnt == 16'h0000;
	endproperty
	a_clear_event: assert property (p_clear_event) else $error("match did not clear counter");

	property p_init_level;
		run_rise && mode == MODE_CMP |=> s_reg.out_lvl == $past(s_reg.ctrl1[C1_INIT]);
	endproperty
	a_init_level: assert property (p_init_level) else $error("output not at initial level");

	property p_capture_a;
		cap_ev && s_reg.cap_clear == 2'h0 |=> s_reg.cmp_a == $past(s_reg.cnt) && match_a_event;
	endproperty
	a_capture_a: assert property (p_capture_a) else $error("capture did not latch into A");

	property p_capture_b;
		cap_ev && s_reg.cap_clear != 2'h0 |=> s_reg.cmp_b == $past(s_reg.cnt) && match_a_event;
	endproperty
	a_capture_b: assert property (p_capture_b) else $error("capture did not latch into B");

	property p_ctrl0_low_zero;
		setup && paddr == ADDR_CTRL0 |=> prdata[2:0] == 3'h0 && s_reg.ctrl0[2:0] == 3'h0;
	endproperty
	a_ctrl0_low_zero: assert property (p_ctrl0_low_zero) else $error("control zero low bits nonzero");

	cover property (run_rise ##[1:50] match_a_event);
	cover property (cap_ev && s_reg.cap_clear != 2'h0);
	cover property (mode == MODE_PWM && pin_func == 2'h2 && $changed(primary_timer_output));
	cover property (tick && s_reg.cnt == CNT_MAX);

endmodule

// ==== ptm_timer_test.sv ====
// Self-checking bench for the periodic timer
`timescale 1ns/10ps
module ptm_timer_test import ptm_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, serr, ext_pin, cap_pin, out_p, out_n, ev_a, ev_p;
	int bad_count = 0;
	int comparisons = 0;
	int a_cnt = 0;

	// 20 MHz clock
	always #25 clk = ~clk;
	// Count A events; capture tests judge by count, not by phase
	always @(posedge clk) if (ev_a === 1'b1) a_cnt <= a_cnt + 1;

	ptm_timer u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.external_clock_pin(ext_pin), .capture_input_pin(cap_pin), .primary_timer_output(out_p),
		.inverse_timer_output(out_n), .match_a_event(ev_a), .match_p_event(ev_p));
	ptm_pins u_pins (.clk(clk), .external_clock_pin(ext_pin), .capture_input_pin(cap_pin));

	task automatic test_done;
		if (bad_count == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// One APB transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			bad_count++;
			test_done();
		end
		r = prdata[7:0];
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		apb(1'b1, a, d, r);
	endtask

	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h04, v[15:8]);
	endtask

	task automatic rd16(input logic [7:0] a, output logic [15:0] v);
		logic [7:0] lo, hi;
		apb(1'b0, a, 8'h00, lo);
		apb(1'b0, a + 8'h04, 8'h00, hi);
		v = {hi, lo};
	endtask

	// Stop, set mode, then a run rise
	task automatic start(input logic [7:0] c1, input logic [2:0] ck);
		wr(ADDR_CTRL0, 8'h00);
		wr(ADDR_CTRL1, c1);
		wr(ADDR_CTRL0, {1'b0, ck, 1'b1, 3'b000});
	endtask

	task automatic wait_ev(input logic a, output int n);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while ((a ? ev_a : ev_p) !== 1'b1 && n < 300);
		if ((a ? ev_a : ev_p) !== 1'b1) begin
			bad_count++;
			test_done();
		end
	endtask

	task automatic t_regs;
		logic [7:0] r;
		logic [15:0] v;
		logic [7:0] pairs [3] = '{ADDR_CA_LO, ADDR_CB_LO, ADDR_CP_LO};
		for (int i = 0; i < 11; i++) begin
			apb(1'b0, 8'(i * 4), 8'h00, r);
			chk(r, 16'h0000, "reset value");
		end
		wr(ADDR_CTRL0, 8'h07);
		apb(1'b0, ADDR_CTRL0, 8'h00, r);
		chk(r, 16'h0000, "ctrl0 low bits");
		wr(ADDR_CNT_LO, 8'h5A);
		apb(1'b0, ADDR_CNT_LO, 8'h00, r);
		chk(r, 16'h0000, "counter write");
		wr(ADDR_CTRL1, 8'hC3);
		apb(1'b0, ADDR_CTRL1, 8'h00, r);
		chk(r, 16'h00C3, "ctrl1 rw");
		foreach (pairs[i]) begin
			wr16(pairs[i], 16'hA55A);
			rd16(pairs[i], v);
			chk(v, 16'hA55A, "compare pair rw");
		end
		apb(1'b0, 8'h30, 8'h00, r);
		chk({7'h00, serr, r}, 16'h0100, "unmapped read");
	endtask

	// Period and clear source; all four pin actions
	task automatic t_cmp;
		int n;
		logic [3:0] e = 4'b0100;
		wr16(ADDR_CA_LO, 16'h0004);
		wr16(ADDR_CP_LO, 16'h0009);
		start(8'h00, CK_SYS);
		wait_ev(1'b0, n);
		wait_ev(1'b0, n);
		chk(16'(n), 16'd10, "period match");
		start(8'h01, CK_SYS);
		wait_ev(1'b1, n);
		wait_ev(1'b1, n);
		chk(16'(n), 16'd5, "A match clear");
		for (int p = 0; p < 4; p++) begin
			start({2'b00, 2'(p), p[0], 3'b000}, CK_SYS);
			repeat (3) @(posedge clk);
			chk({15'h0000, out_p}, {15'h0000, p[0]}, "initial level");
			wait_ev(1'b1, n);
			repeat (3) @(posedge clk);
			chk({15'h0000, out_p}, {15'h0000, e[p]}, "pin action");
			chk({15'h0000, out_n}, {15'h0000, ~e[p]}, "inverse pin");
		end
	endtask

	// Forced levels with polarity, then duty count
	task automatic t_pwm;
		int h;
		for (int i = 0; i < 4; i++) begin
			start({2'b10, 1'b0, i[0], 1'b1, i[1], 2'b00}, CK_SYS);
			repeat (4) @(posedge clk);
			chk({15'h0000, out_p}, {15'h0000, i[0] ^ i[1]}, "forced level");
		end
		wr16(ADDR_CA_LO, 16'h0003);
		for (int i = 0; i < 2; i++) begin
			start({4'b1010, i[0], 3'b000}, CK_SYS);
			repeat (20) @(posedge clk);
			h = 0;
			repeat (10) @(posedge clk) h += (out_p === 1'b1);
			chk(16'(h), i[0] ? 16'd3 : 16'd7, "pwm duty");
		end
	endtask

	// Clock sources, pause and stop
	task automatic t_clk;
		int dv [6] = '{4, 1, 16, 64, SUB_DIV, SUB_DIV};
		logic [15:0] v, w;
		wr16(ADDR_CP_LO, 16'h0000);
		for (int c = 0; c < 8; c++) begin
			start(8'hC0, 3'(c));
			if (c >= 6) u_pins.ext_pulses(5);
			else repeat (1280) @(posedge clk);
			wr(ADDR_CTRL0, 8'h00);
			rd16(ADDR_CNT_LO, v);
			w = (c >= 6) ? 16'd5 : 16'(1280 / dv[c]);
			chk({15'h0000, v + 16'd3 >= w && v <= w + 16'd3}, 16'h0001, "counter rate");
		end
		rd16(ADDR_CNT_LO, w);
		chk(w, v, "stopped holds");
		start(8'hC0, CK_SYS);
		wr(ADDR_CTRL0, 8'h98);
		rd16(ADDR_CNT_LO, v);
		repeat (10) @(posedge clk);
		rd16(ADDR_CNT_LO, w);
		chk(w, v, "pause holds");
		wr(ADDR_CTRL0, 8'h18);
		rd16(ADDR_CNT_LO, w);
		chk({15'h0000, w > v}, 16'h0001, "resume");
	endtask

	// Capture edges into A, then into B with edge clear
	task automatic t_cap;
		int k;
		logic [7:0] r;
		logic [15:0] b, v;
		int ne [4] = '{1, 1, 2, 0};
		for (int p = 0; p < 4; p++) begin
			wr16(ADDR_CA_LO, 16'hFFFF);
			start({2'b01, 2'(p), 4'b0000}, CK_SYS);
			repeat (10) @(posedge clk);
			k = a_cnt;
			u_pins.cap_level(1'b1);
			u_pins.cap_level(1'b0);
			chk(16'(a_cnt - k), 16'(ne[p]), "capture edges");
		end
		wr(ADDR_CAPC, 8'h02);
		start(8'h42, CK_SYS);
		repeat (30) @(posedge clk);
		u_pins.ext_pulses(1);
		rd16(ADDR_CB_LO, b);
		chk({15'h0000, b != 16'h0000}, 16'h0001, "capture into B");
		rd16(ADDR_CA_LO, v);
		chk(v, 16'hFFFF, "A untouched");
		rd16(ADDR_CNT_LO, v);
		chk({15'h0000, v < b}, 16'h0001, "edge clear");
		apb(1'b0, ADDR_CAPC, 8'h00, r);
		chk(r, 16'h0003, "latch edge flag");
	endtask

	// Single pulse from the run bit, then from the clock pin
	task automatic t_pulse;
		int k;
		logic [7:0] r;
		wr16(ADDR_CA_LO, 16'h0003);
		start(8'hB8, CK_SYS);
		repeat (2) @(posedge clk);
		chk({15'h0000, out_p}, 16'h0001, "pulse leading edge");
		repeat (6) @(posedge clk);
		chk({15'h0000, out_p}, 16'h0000, "pulse trailing edge");
		apb(1'b0, ADDR_CTRL0, 8'h00, r);
		chk(r, 16'h0010, "pulse stops run");
		k = a_cnt;
		u_pins.ext_pulses(1);
		// Event count settles one clock after the pin model returns
		repeat (2) @(posedge clk);
		chk(16'(a_cnt - k), 16'h0001, "pin triggered pulse");
		apb(1'b0, ADDR_CTRL0, 8'h00, r);
		chk(r, 16'h0010, "pin pulse stops run");
	endtask

	// Zero period lets the counter run to its maximum and wrap
	task automatic t_wrap;
		int n;
		logic [15:0] v;
		wr16(ADDR_CP_LO, 16'h0000);
		start(8'hC0, CK_SYS);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ev_p !== 1'b1 && n < 70000);
		if (ev_p !== 1'b1) begin
			bad_count++;
			test_done();
		end
		chk({15'h0000, n >= 65536 && n <= 65540}, 16'h0001, "overflow period");
		rd16(ADDR_CNT_LO, v);
		chk({15'h0000, v < 16'd16}, 16'h0001, "counter wrapped");
	endtask

	// Reset held 12 clocks, then every scenario
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_cmp();
		t_pwm();
		t_clk();
		t_cap();
		t_pulse();
		t_wrap();
		test_done();
	end
endmodule
